//--- core/bitop_defs.svh
/*
  Constants for the toggle and overflow-branch executor.
  Assumes inclusion by bare name from core/.
*/
`ifndef BITOP_DEFS_SVH
`define BITOP_DEFS_SVH
`define TOGGLE_OPCODE   4'h7
`define BRANCH_OPCODE   8'hE4
`define ILO_LIMIT       8'h5F
`define ACCESS_SPLIT    8'h60
`define ACCESS_HI_BANK  4'hF
`define PHASE_COUNT     4
`endif

//--- core/bitop_pkg.sv
/*
  Types for the toggle and overflow-branch executor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bitop_pkg;
  typedef enum logic [3:0]
  {
    PH_DECODE  = 4'h1,
    PH_READ    = 4'h2,
    PH_PROCESS = 4'h4,
    PH_WRITE   = 4'h8
  } phase_e;
endpackage

//--- core/bit_flip.sv
/*
  Inverts one selected bit of a byte.
  Assumes a 3-bit bit index.
*/
`timescale 1ns/1ps
module bit_flip
(
  // Data
  input  wire logic [7:0] din,
  input  wire logic [2:0] sel,
  output logic      [7:0] dout
);
  // (RL1) single bit invert
  assign dout = din ^ (8'h01 << sel);
endmodule // bit_flip

//--- core/bit_toggle_and_overflow_branch.sv
/*
  Executes the bit toggle and branch-on-overflow instructions
  over a four-phase instruction cycle.
  Assumes instr and pc_inc are stable for the whole cycle, rd_data valid
  in the same cycle as rd_en, and the core ignores other opcodes here.
*/
// Functional notes
// (RL1) Toggle flips only selected bit, no flags
// (RL2) Access bit zero selects access bank
// (RL3) Access bit one uses bank select
// (RL4) Extended set, access zero, small f: indexed
// (RL5) Toggle: one word, one cycle, four phases
// (RL6) Upper byte E4 decodes overflow branch
// (RL7) Branch only on overflow, flags untouched
// (RL8) Target is incremented pc plus 2n
// (RL9) Taken: two cycles; not taken: one
// (RL10) Not taken: pc sequential, no write
`timescale 1ns/1ps
`include "bitop_defs.svh"
module bit_toggle_and_overflow_branch
  import bitop_pkg::*;
#(
  parameter int PC_W = 21
)
(
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            arst_n,
  // Instruction stream
  input  wire logic [15:0]     instr,
  input  wire logic [PC_W-1:0] pc_inc,
  // Core state
  input  wire logic [3:0]      bank_select_register,
  input  wire logic [11:0]     index_base,
  input  wire logic            ext_set_en,
  input  wire logic            ovf_flag,
  // Data memory
  input  wire logic [7:0]      rd_data,
  output logic      [11:0]     mem_addr,
  output logic                 rd_en,
  output logic                 wr_en,
  output logic      [7:0]      wr_data,
  // Program counter
  output logic                 pc_load,
  output logic      [PC_W-1:0] pc_target,
  output logic                 flush_nop,
  output logic      [3:0]      phase
);
  // Offset field plus the appended zero bit needs at least nine pc bits
  if (PC_W < 9)
  begin : g_pc_w_check
    $error("PC_W too small");
  end

  ////////////////////////////////////////////////////////////////////
  phase_e   ph_reg;
  phase_e   ph_next;
  logic     nop_reg;
  logic     taken_reg;
  logic [7:0] data_reg;
  logic [7:0] flipped;

  wire        bit_toggle_instr         = instr[15:12] == `TOGGLE_OPCODE;
  // (RL6) branch opcode decode
  wire        branch_on_overflow_instr = instr[15:8] == `BRANCH_OPCODE;
  wire [7:0]  f_field   = instr[7:0];
  wire        acc_sel   = instr[8];
  wire [2:0]  bit_sel   = instr[11:9];
  // (RL4) indexed literal offset select
  wire        use_index = ext_set_en && !acc_sel && (f_field <= `ILO_LIMIT);
  // (RL2) access bank split
  wire [11:0] acc_addr  = (f_field < `ACCESS_SPLIT) ? {4'h0, f_field}
                                                  : {`ACCESS_HI_BANK, f_field};
  // (RL3) bank select addressing
  wire [11:0] bank_addr = {bank_select_register, f_field};
  wire [11:0] eff_addr  = use_index ? index_base + {4'h0, f_field}
                        : (acc_sel ? bank_addr : acc_addr);
  // (RL8) sign-extended doubled offset
  wire [PC_W-1:0] offs  = {{(PC_W-9){instr[7]}}, instr[7:0], 1'b0};
  // (RL7) taken only on overflow
  wire        take      = branch_on_overflow_instr && ovf_flag && !nop_reg;
  wire        act       = !nop_reg;
  // Nop marker spans the whole cycle after a taken branch
  wire        flush_next = (ph_next == PH_DECODE) ? taken_reg
                         : (flush_nop && ph_reg != PH_WRITE);

  bit_flip bit_flip_inst
  (
    .din  (data_reg),
    .sel  (bit_sel),
    .dout (flipped)
  );

  // (RL5) four phase sequence
  always_comb
  begin
    case (ph_reg)
      PH_DECODE:  ph_next = PH_READ;
      PH_READ:    ph_next = PH_PROCESS;
      PH_PROCESS: ph_next = PH_WRITE;
      PH_WRITE:   ph_next = PH_DECODE;
      default:    ph_next = PH_DECODE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ph_reg    <= PH_DECODE;
      nop_reg   <= 1'b0;
      taken_reg <= 1'b0;
      data_reg  <= 8'h00;
    end
    else
    begin
      ph_reg <= ph_next;
      // Memory must answer within Q2; the byte is taken at its end
      if (ph_reg == PH_READ)
        data_reg <= rd_data;
      if (ph_reg == PH_PROCESS)
        taken_reg <= take;
      // (RL9) taken branch adds nop cycle
      if (ph_reg == PH_WRITE)
        nop_reg <= taken_reg;
    end
  end

  // Outputs registered one cycle ahead of their phase
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_addr  <= 12'h000;
      rd_en     <= 1'b0;
      wr_en     <= 1'b0;
      wr_data   <= 8'h00;
      pc_load   <= 1'b0;
      pc_target <= '0;
      flush_nop <= 1'b0;
      phase     <= 4'h1;
    end
    else
    begin
      phase     <= ph_next;
      mem_addr  <= eff_addr;
      rd_en     <= act && bit_toggle_instr && ph_reg == PH_DECODE;
      // (RL1) write back toggled byte
      wr_en     <= act && bit_toggle_instr && ph_reg == PH_PROCESS;
      wr_data   <= flipped;
      // (RL10) no pc write when clear
      pc_load   <= ph_reg == PH_PROCESS && take;
      pc_target <= pc_inc + offs;
      flush_nop <= flush_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  a_write_in_q4: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_en |-> phase == 4'h8) else $error("write outside fourth phase"); // (RL5)
  a_pc_needs_ovf: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ph_reg == PH_PROCESS && branch_on_overflow_instr && !ovf_flag
    |=> !pc_load) else $error("pc loaded without overflow"); // (RL10)
  a_pc_in_q4: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pc_load |-> phase == 4'h8) else $error("pc load outside fourth phase"); // (RL9)
  a_nop_follows: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pc_load |=> !pc_load [*4]) else $error("no nop after taken branch"); // (RL9)
  a_one_bit_flip: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_en |-> $countones(wr_data ^ data_reg) == 1) else $error("toggle bad"); // (RL1)
  a_flip_index: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_en |-> wr_data[bit_sel] != data_reg[bit_sel]) else $error("wrong bit"); // (RL1)
  a_bank_addr: assert property (@(posedge clk_sys) disable iff (!arst_n)
    acc_sel |=> mem_addr[11:8] == $past(bank_select_register)) else $error("bank"); // (RL3)
  a_index_addr: assert property (@(posedge clk_sys) disable iff (!arst_n)
    use_index |=> mem_addr == $past(index_base) + {4'h0, $past(f_field)})
    else $error("indexed address wrong"); // (RL4)
  a_access_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !acc_sel && !ext_set_en && f_field < 8'h60 |=> mem_addr[11:8] == 4'h0)
    else $error("access bank wrong"); // (RL2)
  a_target: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pc_load |-> pc_target == $past(pc_inc) + $past(offs)) else $error("target"); // (RL8)

  ////////////////////////////////////////////////////////////////////
  // Guards on the datapath and the nop cycle
  // (RL1) neighbouring bits kept
  a_other_bits: assert property (@(posedge clk_sys) disable iff (!arst_n) // (RL1)
    wr_en |-> ((wr_data ^ data_reg) & ~(8'h01 << bit_sel)) == 8'h00)
    else $error("neighbour bit changed");

  // (RL5) read in second phase
  a_read_in_q2: assert property (@(posedge clk_sys) disable iff (!arst_n) // (RL5)
    rd_en |-> phase == 4'h2)
    else $error("read outside second phase");
  // (RL5) phase stays one-hot
  a_phase_onehot: assert property (@(posedge clk_sys) disable iff (!arst_n) // (RL5)
    $onehot(phase))
    else $error("phase not one-hot");
  // (RL7) branch never writes memory
  a_branch_no_wr: assert property (@(posedge clk_sys) disable iff (!arst_n) // (RL7)
    pc_load |-> !wr_en)
    else $error("memory write during branch");

  // (RL9) nop cycle spans four clocks
  a_nop_length: assert property (@(posedge clk_sys) disable iff (!arst_n) // (RL9)
    pc_load |=> flush_nop [*4])
    else $error("nop cycle too short");
  // (RL9) nothing happens in the nop cycle
  a_nop_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // (RL9)
    flush_nop |-> !rd_en && !wr_en && !pc_load)
    else $error("activity during nop cycle");
  // (RL10) not taken means no write
  a_clear_no_wr: assert property (@(posedge clk_sys) disable iff (!arst_n) // (RL10)
    ph_reg == PH_PROCESS && branch_on_overflow_instr && !ovf_flag |=> !wr_en)
    else $error("write on untaken branch");

  c_toggle: cover property (@(posedge clk_sys) wr_en);
  c_not_taken: cover property (@(posedge clk_sys)
    ph_reg == PH_PROCESS && branch_on_overflow_instr && !ovf_flag);
  c_nop_cycle: cover property (@(posedge clk_sys) flush_nop);
  c_taken: cover property (@(posedge clk_sys) pc_load);
  c_indexed: cover property (@(posedge clk_sys) use_index && bit_toggle_instr);
endmodule // bit_toggle_and_overflow_branch

//--- verif/test_bit_toggle_and_overflow_branch.sv
/*
  Self-checking bench for the toggle and overflow-branch executor.
  Assumes the core package and design files are compiled first.
*/
`timescale 1ns/1ps
module test_bit_toggle_and_overflow_branch
  import bitop_pkg::*;
;
  logic        clk_sys, arst_n, ext_set_en, ovf_flag, rd_en, wr_en, pc_load, flush_nop, fl;
  logic [15:0] instr;
  logic [20:0] pc_inc, pc_target, got_t;
  logic [3:0]  bank_select_register, phase;
  logic [11:0] index_base, mem_addr, got_a;
  logic [7:0]  rd_data, wr_data, got_d;
  int          mismatches, n_compared, rt, wt, pt;

  bit_toggle_and_overflow_branch #(.PC_W(21)) bit_toggle_and_overflow_branch_inst
  (
    .clk_sys(clk_sys), .arst_n(arst_n), .instr(instr), .pc_inc(pc_inc),
    .bank_select_register(bank_select_register), .index_base(index_base),
    .ext_set_en(ext_set_en), .ovf_flag(ovf_flag), .rd_data(rd_data), .mem_addr(mem_addr),
    .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data), .pc_load(pc_load),
    .pc_target(pc_target), .flush_nop(flush_nop), .phase(phase)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // New word lands on the edge entering Q1, then five clocks are watched
  task automatic exec(input logic [15:0] i, input logic ov, input logic ext);
    int k = 0;
    {rt, wt, pt} = '0;
    while (phase !== PH_WRITE && k < 20)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k >= 20)
    begin
      mismatches++;
      end_sim();
    end
    @(posedge clk_sys);
    instr <= i;
    ovf_flag <= ov;
    ext_set_en <= ext;
    for (int t = 1; t <= 5; t++)
    begin
      @(posedge clk_sys);
      #1;
      if (rd_en === 1'b1 && rt == 0) rt = t;
      if (wr_en === 1'b1 && wt == 0) wt = t;
      if (pc_load === 1'b1 && pt == 0) pt = t;
      if (t == 4) {got_a, got_d, got_t} = {mem_addr, wr_data, pc_target};
      if (t == 5) fl = flush_nop;
    end
  endtask

  task automatic toggle_case(input logic [2:0] b, input logic a, input logic [7:0] f,
                             input logic ext);
    logic [11:0] ea;
    if (a) ea = {bank_select_register, f};
    else if (ext && f <= 8'h5F) ea = index_base + 12'(f);
    else ea = (f < 8'h60) ? {4'h0, f} : {4'hF, f};
    exec({4'h7, b, a, f}, 1'b1, ext);
    chk(got_d, 8'h75 ^ (8'h01 << b));
    chk(got_a, ea);
    chk(rt, 1);
    chk(wt, 3);
    chk(pt, 0);
  endtask

  task automatic branch_case(input logic [7:0] op, input logic [7:0] n, input logic ov);
    logic tk;
    tk = ov && op == 8'hE4;
    exec({op, n}, ov, 1'b0);
    chk(pt, tk ? 3 : 0);
    if (tk) chk(got_t, 21'(pc_inc + {{12{n[7]}}, n, 1'b0}));
    chk(fl, tk);
    chk(wt, 0);
  endtask

  task automatic end_sim();
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_toggle_bits();
    for (int b = 0; b < 8; b++) toggle_case(3'(b), 1'b0, 8'h80, 1'b0);
  endtask

  task automatic t_banks();
    toggle_case(3'h3, 1'b0, 8'h20, 1'b0);
    toggle_case(3'h5, 1'b1, 8'h10, 1'b1);
  endtask

  // Boundary of the indexed window
  task automatic t_indexed();
    toggle_case(3'h1, 1'b0, 8'h5F, 1'b1);
    toggle_case(3'h2, 1'b0, 8'h60, 1'b1);
    toggle_case(3'h6, 1'b0, 8'h00, 1'b1);
  endtask

  task automatic t_branch();
    branch_case(8'hE4, 8'h80, 1'b1);
    branch_case(8'hE4, 8'h7F, 1'b1);
    branch_case(8'hE4, 8'h05, 1'b0);
    branch_case(8'hE0, 8'h10, 1'b1);
    branch_case(8'hE4, 8'hFF, 1'b1);
  endtask

  initial
  begin
    {arst_n, ext_set_en, ovf_flag, instr} = '0;
    {mismatches, n_compared, fl} = '0;
    pc_inc = 21'h001000;
    bank_select_register = 4'hA;
    index_base = 12'h300;
    rd_data = 8'h75;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_toggle_bits();
    t_banks();
    t_indexed();
    t_branch();
    end_sim();
  end
endmodule // test_bit_toggle_and_overflow_branch
